// file: pcr_bank.sv
// phase calibration register bank with its correction datapath
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcr_bank (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [pcr_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [pcr_pkg::DATA_W-1:0] wdata,
   input wire logic [pcr_pkg::STRB_W-1:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [pcr_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [pcr_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // phase a rms results in
   input wire logic [31:0] a_fund_current_rms_result,
   input wire logic [31:0] a_fund_voltage_rms_result,
   input wire logic [31:0] a_halfcycle_voltage_rms_result,
   input wire logic [31:0] a_halfcycle_current_rms_result,
   input wire logic [31:0] a_multicycle_voltage_rms_result,
   input wire logic [31:0] a_multicycle_current_rms_result,
   // phase a rms results corrected
   output logic [31:0] a_fund_current_rms_corr,
   output logic [31:0] a_fund_voltage_rms_corr,
   output logic [31:0] a_halfcycle_voltage_rms_corr,
   output logic [31:0] a_halfcycle_current_rms_corr,
   output logic [31:0] a_multicycle_voltage_rms_corr,
   output logic [31:0] a_multicycle_current_rms_corr,
   // phase b channel samples in
   input wire logic [31:0] b_current_sample,
   input wire logic [31:0] b_voltage_sample,
   // phase b channel samples corrected
   output logic [31:0] b_current_sample_corr,
   output logic [31:0] b_voltage_sample_corr,
   output logic [31:0] b_phase_corr_sel,
   // phase b rms results in and corrected
   input wire logic [31:0] b_current_rms_result,
   input wire logic [31:0] b_voltage_rms_result,
   output logic [31:0] b_current_rms_corr,
   output logic [31:0] b_voltage_rms_corr,
   // phase b power results in
   input wire logic [31:0] b_total_active_power,
   input wire logic [31:0] b_total_reactive_power,
   input wire logic [31:0] b_total_apparent_power,
   input wire logic [31:0] b_fund_active_power,
   input wire logic [31:0] b_fund_reactive_power,
   input wire logic [31:0] b_fund_apparent_power,
   // phase b power results corrected
   output logic [31:0] b_total_active_power_corr,
   output logic [31:0] b_total_reactive_power_corr,
   output logic [31:0] b_total_apparent_power_corr,
   output logic [31:0] b_fund_active_power_corr,
   output logic [31:0] b_fund_reactive_power_corr,
   output logic [31:0] b_fund_apparent_power_corr
);
   import pcr_pkg::*;

   // index to storage slot; NREG marks an unmapped index
   function automatic logic [4:0] slot_of(input logic [11:0] idx);
      logic [4:0] s;
      s = 5'(NREG);
      for (int i = 0; i < NREG; i++) begin
         if (REG_INDEX[i] == idx) s = 5'(i);
      end
      return s;
   endfunction

   // byte-lane merge of a write into the stored word
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) m[8*b +: 8] = new_v[8*b +: 8];
      end
      return m;
   endfunction

   // signed scaling by (1 + gain), gain a signed fraction
   function automatic logic [31:0] scale(input logic [31:0] x, input logic [31:0] g);
      logic signed [63:0] p;
      p = $signed(x) * $signed(g);
      return x + 32'(p >>> GAIN_FRAC);
   endfunction

   // offset correction of a result
   function automatic logic [31:0] add_os(input logic [31:0] x, input logic [31:0] os);
      return x + os;
   endfunction

   logic [31:0] regs_r [0:NREG-1];
   logic aw_full_r;
   logic w_full_r;
   logic [11:0] aw_idx_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic wr_commit;
   logic [4:0] wr_slot;
   logic [4:0] rd_slot;
   logic [31:0] rd_word;
   logic [ZONE_W-1:0] zone_idx;
   logic mp_en;
   logic [31:0] cur_stage1;

   // ---------------- axi4-lite write path ----------------
   assign awready = !aw_full_r && !bvalid_r;
   assign wready = !w_full_r && !bvalid_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign wr_commit = aw_full_r && w_full_r && !bvalid_r;
   assign wr_slot = slot_of(aw_idx_r);

   // address and data are caught independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         aw_idx_r <= 12'h000;
      end else if (awvalid && awready) begin
         aw_full_r <= 1'b1;
         aw_idx_r <= awaddr[ADDR_W-1:2];
      end else if (wr_commit) begin
         aw_full_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
      end else if (wvalid && wready) begin
         w_full_r <= 1'b1;
         w_data_r <= wdata;
         w_strb_r <= wstrb;
      end else if (wr_commit) begin
         w_full_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_commit) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wr_slot == 5'(NREG)) ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // calibration storage; unmapped writes change nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NREG; i++) begin
            regs_r[i] <= RST_CAL;
         end
      end else if (wr_commit && wr_slot != 5'(NREG)) begin
         regs_r[wr_slot] <= merge(regs_r[wr_slot], w_data_r, w_strb_r);
      end
   end

   // ---------------- axi4-lite read path ----------------
   assign arready = !rvalid_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign rd_slot = slot_of(araddr[ADDR_W-1:2]);

   // config word: only the stored enable bit reads back, the live zone reads back above it
   always_comb begin
      rd_word = 32'h00000000;
      if (rd_slot == slot_of(IDX_MAIN_CONFIG_REGISTER)) begin
         rd_word[MP_EN_BIT] = mp_en;
         rd_word[ZONE_LSB +: ZONE_W] = zone_idx;
      end else if (rd_slot != 5'(NREG)) begin
         rd_word = regs_r[rd_slot];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= (rd_slot == 5'(NREG)) ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ---------------- multipoint zone selection ----------------
   assign mp_en = regs_r[slot_of(IDX_MAIN_CONFIG_REGISTER)][MP_EN_BIT];

   pcr_zone_select u_zone (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(mp_en),
      .rms(b_current_rms_result),
      .low_thr_0(regs_r[slot_of(IDX_MULTIPOINT_LOW_THRESHOLD_0)]),
      .low_thr_1(regs_r[slot_of(IDX_MULTIPOINT_LOW_THRESHOLD_1)]),
      .low_thr_2(regs_r[slot_of(IDX_MULTIPOINT_LOW_THRESHOLD_2)]),
      .low_thr_3(regs_r[slot_of(IDX_MULTIPOINT_LOW_THRESHOLD_3)]),
      .high_thr_0(regs_r[slot_of(IDX_MULTIPOINT_HIGH_THRESHOLD_0)]),
      .high_thr_1(regs_r[slot_of(IDX_MULTIPOINT_HIGH_THRESHOLD_1)]),
      .high_thr_2(regs_r[slot_of(IDX_MULTIPOINT_HIGH_THRESHOLD_2)]),
      .high_thr_3(regs_r[slot_of(IDX_MULTIPOINT_HIGH_THRESHOLD_3)]),
      .zone_idx(zone_idx)
   );

   // ---------------- phase b channel correction ----------------
   assign cur_stage1 = scale(b_current_sample, regs_r[slot_of(IDX_B_CURRENT_GAIN)]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         b_current_sample_corr <= 32'h00000000;
         b_voltage_sample_corr <= 32'h00000000;
      end else begin
         if (mp_en) begin
            b_current_sample_corr <= scale(cur_stage1,
               regs_r[slot_of(IDX_B_MULTIPOINT_GAIN_0) + 5'(zone_idx)]);
         end else begin
            b_current_sample_corr <= cur_stage1;
         end
         b_voltage_sample_corr <= scale(b_voltage_sample,
            regs_r[slot_of(IDX_B_VOLTAGE_GAIN)]);
      end
   end

   // zone stays at zero while multipoint is off, so the first register is used
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         b_phase_corr_sel <= 32'h00000000;
      end else if (mp_en) begin
         b_phase_corr_sel <= regs_r[slot_of(IDX_B_PHASE_CORR_0) + 5'(zone_idx)];
      end else begin
         b_phase_corr_sel <= regs_r[slot_of(IDX_B_PHASE_CORR_0)];
      end
   end

   // ---------------- phase b power correction ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         b_total_active_power_corr <= 32'h00000000;
         b_total_reactive_power_corr <= 32'h00000000;
         b_total_apparent_power_corr <= 32'h00000000;
         b_fund_active_power_corr <= 32'h00000000;
         b_fund_reactive_power_corr <= 32'h00000000;
         b_fund_apparent_power_corr <= 32'h00000000;
      end else begin
         b_total_active_power_corr <= add_os(
            scale(b_total_active_power, regs_r[slot_of(IDX_B_POWER_GAIN)]),
            regs_r[slot_of(IDX_B_ACTIVE_POWER_OFFSET)]);
         b_total_reactive_power_corr <= scale(b_total_reactive_power,
            regs_r[slot_of(IDX_B_POWER_GAIN)]);
         b_total_apparent_power_corr <= scale(b_total_apparent_power,
            regs_r[slot_of(IDX_B_POWER_GAIN)]);
         b_fund_active_power_corr <= scale(b_fund_active_power,
            regs_r[slot_of(IDX_B_POWER_GAIN)]);
         b_fund_reactive_power_corr <= scale(b_fund_reactive_power,
            regs_r[slot_of(IDX_B_POWER_GAIN)]);
         b_fund_apparent_power_corr <= scale(b_fund_apparent_power,
            regs_r[slot_of(IDX_B_POWER_GAIN)]);
      end
   end

   // ---------------- rms offset correction ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         b_current_rms_corr <= 32'h00000000;
         b_voltage_rms_corr <= 32'h00000000;
      end else begin
         b_current_rms_corr <= add_os(b_current_rms_result,
            regs_r[slot_of(IDX_B_CURRENT_RMS_OFFSET)]);
         b_voltage_rms_corr <= add_os(b_voltage_rms_result,
            regs_r[slot_of(IDX_B_VOLTAGE_RMS_OFFSET)]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_fund_current_rms_corr <= 32'h00000000;
         a_fund_voltage_rms_corr <= 32'h00000000;
         a_halfcycle_voltage_rms_corr <= 32'h00000000;
         a_halfcycle_current_rms_corr <= 32'h00000000;
         a_multicycle_voltage_rms_corr <= 32'h00000000;
         a_multicycle_current_rms_corr <= 32'h00000000;
      end else begin
         a_fund_current_rms_corr <= add_os(a_fund_current_rms_result,
            regs_r[slot_of(IDX_A_FUND_CURRENT_RMS_OFFSET)]);
         a_fund_voltage_rms_corr <= add_os(a_fund_voltage_rms_result,
            regs_r[slot_of(IDX_A_FUND_VOLTAGE_RMS_OFFSET)]);
         a_halfcycle_voltage_rms_corr <= add_os(a_halfcycle_voltage_rms_result,
            regs_r[slot_of(IDX_A_HALFCYCLE_VOLTAGE_RMS_OFFSET)]);
         a_halfcycle_current_rms_corr <= add_os(a_halfcycle_current_rms_result,
            regs_r[slot_of(IDX_A_HALFCYCLE_CURRENT_RMS_OFFSET)]);
         a_multicycle_voltage_rms_corr <= add_os(a_multicycle_voltage_rms_result,
            regs_r[slot_of(IDX_A_MULTICYCLE_VOLTAGE_RMS_OFFSET)]);
         a_multicycle_current_rms_corr <= add_os(a_multicycle_current_rms_result,
            regs_r[slot_of(IDX_A_MULTICYCLE_CURRENT_RMS_OFFSET)]);
      end
   end

   // protection bits carry no meaning for this bank
   logic unused_prot;
   assign unused_prot = ^{awprot, arprot, awaddr[1:0], araddr[1:0]};
endmodule
`default_nettype wire

// file: pcr_bank_sva.sv
// bus handshake checker for the phase calibration register bank
`timescale 1ns/1ps
`default_nettype none
module pcr_bank_sva
   import pcr_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   // read channels
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [pcr_pkg::ADDR_W-1:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [pcr_pkg::DATA_W-1:0] rdata,
   input wire logic [1:0] rresp,
   // datapath
   input wire logic [31:0] b_voltage_sample_corr
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   rd_latency_a: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)
      && $stable(rresp))
      else $error("read answer dropped");
   rd_release_a: assert property (rvalid && rready |=> !rvalid)
      else $error("read answer repeated");
   wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   wr_latency_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write answer late");
   wr_block_a: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answer pending");
   rd_unmapped_a: assert property (arvalid && arready && araddr[13:2] == 12'h019
      |=> rresp == RESP_SLVERR && rdata == 32'h00000000)
      else $error("unmapped read not refused");
   rst_idle_a: assert property ($rose(aresetn) |-> !bvalid && !rvalid
      && b_voltage_sample_corr == 32'h00000000)
      else $error("outputs not idle after reset");
   cover property (bvalid && bready);
   cover property (rvalid && rready && rresp == RESP_OKAY);
   cover property (rvalid && rresp == RESP_SLVERR);
endmodule
`default_nettype wire

// file: pcr_pkg.sv
// constants, register map and types for the phase calibration register bank
package pcr_pkg;
   // bus geometry
   localparam int ADDR_W = 14;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // register indices, byte address is four times the index
   localparam logic [11:0] IDX_A_FUND_CURRENT_RMS_OFFSET = 12'h013;
   localparam logic [11:0] IDX_A_FUND_VOLTAGE_RMS_OFFSET = 12'h014;
   localparam logic [11:0] IDX_A_HALFCYCLE_VOLTAGE_RMS_OFFSET = 12'h015;
   localparam logic [11:0] IDX_A_HALFCYCLE_CURRENT_RMS_OFFSET = 12'h016;
   localparam logic [11:0] IDX_A_MULTICYCLE_VOLTAGE_RMS_OFFSET = 12'h017;
   localparam logic [11:0] IDX_A_MULTICYCLE_CURRENT_RMS_OFFSET = 12'h018;
   localparam logic [11:0] IDX_B_CURRENT_GAIN = 12'h020;
   localparam logic [11:0] IDX_B_MULTIPOINT_GAIN_0 = 12'h021;
   localparam logic [11:0] IDX_B_MULTIPOINT_GAIN_1 = 12'h022;
   localparam logic [11:0] IDX_B_MULTIPOINT_GAIN_2 = 12'h023;
   localparam logic [11:0] IDX_B_MULTIPOINT_GAIN_3 = 12'h024;
   localparam logic [11:0] IDX_B_MULTIPOINT_GAIN_4 = 12'h025;
   localparam logic [11:0] IDX_B_PHASE_CORR_0 = 12'h026;
   localparam logic [11:0] IDX_B_PHASE_CORR_1 = 12'h027;
   localparam logic [11:0] IDX_B_PHASE_CORR_2 = 12'h028;
   localparam logic [11:0] IDX_B_PHASE_CORR_3 = 12'h029;
   localparam logic [11:0] IDX_B_PHASE_CORR_4 = 12'h02A;
   localparam logic [11:0] IDX_B_VOLTAGE_GAIN = 12'h02B;
   localparam logic [11:0] IDX_B_CURRENT_RMS_OFFSET = 12'h02C;
   localparam logic [11:0] IDX_B_VOLTAGE_RMS_OFFSET = 12'h02D;
   localparam logic [11:0] IDX_B_POWER_GAIN = 12'h02E;
   localparam logic [11:0] IDX_B_ACTIVE_POWER_OFFSET = 12'h02F;
   localparam logic [11:0] IDX_MAIN_CONFIG_REGISTER = 12'h060;
   localparam logic [11:0] IDX_MULTIPOINT_LOW_THRESHOLD_0 = 12'h061;
   localparam logic [11:0] IDX_MULTIPOINT_LOW_THRESHOLD_1 = 12'h062;
   localparam logic [11:0] IDX_MULTIPOINT_LOW_THRESHOLD_2 = 12'h063;
   localparam logic [11:0] IDX_MULTIPOINT_LOW_THRESHOLD_3 = 12'h064;
   localparam logic [11:0] IDX_MULTIPOINT_HIGH_THRESHOLD_0 = 12'h065;
   localparam logic [11:0] IDX_MULTIPOINT_HIGH_THRESHOLD_1 = 12'h066;
   localparam logic [11:0] IDX_MULTIPOINT_HIGH_THRESHOLD_2 = 12'h067;
   localparam logic [11:0] IDX_MULTIPOINT_HIGH_THRESHOLD_3 = 12'h068;
   // storage slot k holds the register whose index is REG_INDEX[k]
   localparam int NREG = 31;
   localparam logic [11:0] REG_INDEX [0:NREG-1] = '{
      IDX_A_FUND_CURRENT_RMS_OFFSET, IDX_A_FUND_VOLTAGE_RMS_OFFSET,
      IDX_A_HALFCYCLE_VOLTAGE_RMS_OFFSET, IDX_A_HALFCYCLE_CURRENT_RMS_OFFSET,
      IDX_A_MULTICYCLE_VOLTAGE_RMS_OFFSET, IDX_A_MULTICYCLE_CURRENT_RMS_OFFSET,
      IDX_B_CURRENT_GAIN, IDX_B_MULTIPOINT_GAIN_0, IDX_B_MULTIPOINT_GAIN_1,
      IDX_B_MULTIPOINT_GAIN_2, IDX_B_MULTIPOINT_GAIN_3, IDX_B_MULTIPOINT_GAIN_4,
      IDX_B_PHASE_CORR_0, IDX_B_PHASE_CORR_1, IDX_B_PHASE_CORR_2,
      IDX_B_PHASE_CORR_3, IDX_B_PHASE_CORR_4, IDX_B_VOLTAGE_GAIN,
      IDX_B_CURRENT_RMS_OFFSET, IDX_B_VOLTAGE_RMS_OFFSET, IDX_B_POWER_GAIN,
      IDX_B_ACTIVE_POWER_OFFSET, IDX_MAIN_CONFIG_REGISTER,
      IDX_MULTIPOINT_LOW_THRESHOLD_0, IDX_MULTIPOINT_LOW_THRESHOLD_1,
      IDX_MULTIPOINT_LOW_THRESHOLD_2, IDX_MULTIPOINT_LOW_THRESHOLD_3,
      IDX_MULTIPOINT_HIGH_THRESHOLD_0, IDX_MULTIPOINT_HIGH_THRESHOLD_1,
      IDX_MULTIPOINT_HIGH_THRESHOLD_2, IDX_MULTIPOINT_HIGH_THRESHOLD_3};
   // reset value of every calibration register
   localparam logic [31:0] RST_CAL = 32'h00000000;
   // main config register fields
   localparam int MP_EN_BIT = 0;
   localparam int ZONE_LSB = 8;
   localparam int ZONE_W = 3;
   // gains are signed fractions scaled by two to this power
   localparam int GAIN_FRAC = 23;
   // current amplitude zones for multipoint compensation
   typedef enum logic [4:0] {
      ZONE_0 = 5'b00001,
      ZONE_1 = 5'b00010,
      ZONE_2 = 5'b00100,
      ZONE_3 = 5'b01000,
      ZONE_4 = 5'b10000
   } pcr_zone_type;
endpackage

// file: pcr_zone_select.sv
// amplitude zone tracker for multipoint gain and phase compensation
`timescale 1ns/1ps
`default_nettype none
module pcr_zone_select (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic enable,
   input wire logic [31:0] rms,
   // thresholds between zone k and zone k+1
   input wire logic [31:0] low_thr_0,
   input wire logic [31:0] low_thr_1,
   input wire logic [31:0] low_thr_2,
   input wire logic [31:0] low_thr_3,
   input wire logic [31:0] high_thr_0,
   input wire logic [31:0] high_thr_1,
   input wire logic [31:0] high_thr_2,
   input wire logic [31:0] high_thr_3,
   // selected zone
   output logic [pcr_pkg::ZONE_W-1:0] zone_idx
);
   import pcr_pkg::*;

   pcr_zone_type zone_r;
   pcr_zone_type zone_nxt;

   // move up past the high threshold, down below the low one; the gap gives hysteresis
   always_comb begin
      zone_nxt = zone_r;
      case (zone_r)
         ZONE_0: if (rms >= high_thr_0) zone_nxt = ZONE_1;
         ZONE_1: begin
            if (rms >= high_thr_1) zone_nxt = ZONE_2;
            else if (rms < low_thr_0) zone_nxt = ZONE_0;
         end
         ZONE_2: begin
            if (rms >= high_thr_2) zone_nxt = ZONE_3;
            else if (rms < low_thr_1) zone_nxt = ZONE_1;
         end
         ZONE_3: begin
            if (rms >= high_thr_3) zone_nxt = ZONE_4;
            else if (rms < low_thr_2) zone_nxt = ZONE_2;
         end
         ZONE_4: if (rms < low_thr_3) zone_nxt = ZONE_3;
         default: zone_nxt = ZONE_0;
      endcase
   end

   // with multipoint off the tracker parks in the first zone
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         zone_r <= ZONE_0;
      end else begin
         zone_r <= zone_nxt;
      end
   end

   always_comb begin
      case (zone_r)
         ZONE_1: zone_idx = 3'h1;
         ZONE_2: zone_idx = 3'h2;
         ZONE_3: zone_idx = 3'h3;
         ZONE_4: zone_idx = 3'h4;
         default: zone_idx = 3'h0;
      endcase
   end
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking testbench for the phase calibration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pcr_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, din = '0, rdata;
   logic [3:0] wstrb = '0;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] o [17];
   int num_errors = 0, cmp_count = 0;
   // offset rows: register index, written value; output k = din + value
   localparam logic [11:0] ROW_IX [8] = '{12'h013, 12'h014, 12'h015, 12'h016, 12'h017,
      12'h018, 12'h02C, 12'h02D};
   localparam logic [31:0] ROW_VAL [8] = '{32'h00000011, 32'h00000202, 32'h00003003,
      32'h00040004, 32'h00500005, 32'h06000006, 32'h70000007, 32'h00000808};
   always #2.5 aclk = ~aclk;
   pcr_bank i_pcr_bank (
      .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
      .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
      .rready, .rdata, .rresp,
      .a_fund_current_rms_result(din), .a_fund_voltage_rms_result(din),
      .a_halfcycle_voltage_rms_result(din), .a_halfcycle_current_rms_result(din),
      .a_multicycle_voltage_rms_result(din), .a_multicycle_current_rms_result(din),
      .b_current_sample(din), .b_voltage_sample(din), .b_current_rms_result(din),
      .b_voltage_rms_result(din), .b_total_active_power(din), .b_total_reactive_power(din),
      .b_total_apparent_power(din), .b_fund_active_power(din), .b_fund_reactive_power(din),
      .b_fund_apparent_power(din),
      .a_fund_current_rms_corr(o[0]), .a_fund_voltage_rms_corr(o[1]),
      .a_halfcycle_voltage_rms_corr(o[2]), .a_halfcycle_current_rms_corr(o[3]),
      .a_multicycle_voltage_rms_corr(o[4]), .a_multicycle_current_rms_corr(o[5]),
      .b_current_rms_corr(o[6]), .b_voltage_rms_corr(o[7]), .b_current_sample_corr(o[8]),
      .b_voltage_sample_corr(o[9]), .b_phase_corr_sel(o[10]),
      .b_total_active_power_corr(o[11]), .b_total_reactive_power_corr(o[12]),
      .b_total_apparent_power_corr(o[13]), .b_fund_active_power_corr(o[14]),
      .b_fund_reactive_power_corr(o[15]), .b_fund_apparent_power_corr(o[16])
   );
   task automatic give_verdict;
      if (num_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (e !== g) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] ix, input logic [31:0] d, input logic [3:0] s,
         input logic [1:0] er);
      logic got;
      got = 1'b0;
      awaddr <= {ix, 2'h0};
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40 && !got; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         got = bvalid;
         if (got) chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
      bready <= 1'b0;
      @(posedge aclk);
      if (!got) begin
         chk("write timeout", 32'h1, 32'h0);
         give_verdict;
      end
   endtask
   task automatic rd(input logic [11:0] ix, input logic [31:0] e, input logic [1:0] er);
      logic got;
      got = 1'b0;
      araddr <= {ix, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40 && !got; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         got = rvalid;
         if (got) begin
            chk("rdata", e, rdata);
            chk("rresp", {30'h0, er}, {30'h0, rresp});
         end
      end
      rready <= 1'b0;
      @(posedge aclk);
      if (!got) begin
         chk("read timeout", 32'h1, 32'h0);
         give_verdict;
      end
   endtask
   // let the zone tracker and output registers settle, then compare
   task automatic dp(input int k, input logic [31:0] e);
      repeat (4) @(posedge aclk);
      #1 chk($sformatf("output %0d", k), e, o[k]);
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      din <= 32'h00000100;
      for (int i = 0; i < 8; i++) begin
         rd(ROW_IX[i], RST_CAL, RESP_OKAY);
         wr(ROW_IX[i], ROW_VAL[i], 4'hF, RESP_OKAY);
         rd(ROW_IX[i], ROW_VAL[i], RESP_OKAY);
         dp(i, 32'h00000100 + ROW_VAL[i]);
      end
      // half gains, multipoint still off
      wr(IDX_B_CURRENT_GAIN, 32'h00400000, 4'hF, RESP_OKAY);
      wr(IDX_B_VOLTAGE_GAIN, 32'h00400000, 4'hF, RESP_OKAY);
      wr(IDX_B_POWER_GAIN, 32'h00400000, 4'hF, RESP_OKAY);
      wr(IDX_B_ACTIVE_POWER_OFFSET, 32'h00000010, 4'hF, RESP_OKAY);
      wr(IDX_B_PHASE_CORR_0, 32'h0000000A, 4'hF, RESP_OKAY);
      wr(IDX_B_PHASE_CORR_1, 32'h0000000B, 4'hF, RESP_OKAY);
      wr(IDX_B_MULTIPOINT_GAIN_1, 32'h00400000, 4'hF, RESP_OKAY);
      wr(IDX_MULTIPOINT_HIGH_THRESHOLD_0, 32'h00000080, 4'hF, RESP_OKAY);
      for (int k = 1; k < 4; k++)
         wr(IDX_MULTIPOINT_HIGH_THRESHOLD_0 + 12'(k), 32'hFFFFFFFF, 4'hF, RESP_OKAY);
      dp(8, 32'h00000180);
      dp(9, 32'h00000180);
      dp(10, 32'h0000000A);
      dp(11, 32'h00000190);
      for (int k = 12; k < 17; k++) dp(k, 32'h00000180);
      // multipoint on, current amplitude sits in zone 1
      wr(IDX_MAIN_CONFIG_REGISTER, 32'h00000001, 4'hF, RESP_OKAY);
      dp(10, 32'h0000000B);
      dp(8, 32'h00000240);
      rd(IDX_MAIN_CONFIG_REGISTER, 32'h00000101, RESP_OKAY);
      // amplitude falls below the low threshold, tracker steps back to zone 0
      wr(IDX_MULTIPOINT_LOW_THRESHOLD_0, 32'h00000060, 4'hF, RESP_OKAY);
      din <= 32'h00000040;
      dp(10, 32'h0000000A);
      dp(8, 32'h00000060);
      // unmapped place and a single byte lane
      wr(12'h019, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
      rd(12'h019, 32'h00000000, RESP_SLVERR);
      wr(IDX_B_PHASE_CORR_4, 32'hFFFFFFFF, 4'h2, RESP_OKAY);
      rd(IDX_B_PHASE_CORR_4, 32'h0000FF00, RESP_OKAY);
      // second reset in mid-run
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(IDX_B_CURRENT_GAIN, RST_CAL, RESP_OKAY);
      rd(IDX_MAIN_CONFIG_REGISTER, RST_CAL, RESP_OKAY);
      dp(10, RST_CAL);
      give_verdict;
   end
endmodule
bind pcr_bank pcr_bank_sva i_pcr_bank_sva (.aclk, .aresetn, .awvalid, .awready, .wvalid,
   .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
   .rresp, .b_voltage_sample_corr);
`default_nettype wire
